// ==== design/iod_core.sv ====
// Instruction operand decoder and four-phase execution sequencer.
// Assumes program memory presents instrWord steadily during a whole cycle;
// instrValid marks a word ready at the start of an instruction cycle.
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// Functional notes
// [RL1] d=0 result to accumulator, d=1 file
// [RL2] File field addresses registers 0x00-0x7F
// [RL3] Bit field picks one of eight bits
// [RL4] Literal is eight or eleven bits
// [RL5] Instruction cycle equals four oscillator periods
// [RL6] Taken branch adds a trailing no-op cycle
// [RL7] Every file operand is read first
// [RL8] Port register access clears change condition
// [RL9] Don't-care bits never affect behaviour
// [RL10] Words are 14 bits: opcode plus operands
// [RL11] Field layout follows external encoding table
module iod_core
  import iod_pkg::*;
#(
  parameter int WORD_W = IOD_WORD_W
) (
  input  wire logic              ref_clk,
  input  wire logic              arst_n,
  input  wire logic [WORD_W-1:0] instrWord,
  input  wire logic              instrValid,
  input  wire logic              branchTaken,
  input  wire logic [3:0]        aluOp,
  output logic                   cycleStart,
  output logic      [3:0]        phase,
  output logic      [7:0]        accum,
  output logic      [10:0]       literal11,
  output logic      [7:0]        literal8,
  output logic                   inNopCycle,
  output logic                   portReadStrobe,
  output logic      [7:0]        fileOperand
);
  ////////////////////////////////////////////////////////////////////////////
  logic rstMeta;
  logic rstSync;

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rstMeta <= 1'b0;
      rstSync <= 1'b0;
    end else begin
      rstMeta <= 1'b1;
      rstSync <= rstMeta;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Field extraction; only named fields are read so stray bits do nothing
  function automatic logic [1:0] word_class(input logic [13:0] w);
    return w[13:12]; // see [RL10] see [RL11]
  endfunction

  logic [13:0] word;

  assign word = instrWord[13:0]; // see [RL10]

  ////////////////////////////////////////////////////////////////////////////
  iod_phase_t state;
  iod_phase_t next_state;

  always_comb begin
    case (state)
      IOD_Q1:  next_state = IOD_Q2;
      IOD_Q2:  next_state = IOD_Q3;
      IOD_Q3:  next_state = IOD_Q4;
      IOD_Q4:  next_state = IOD_Q1;
      default: next_state = IOD_Q1;
    endcase
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= IOD_Q1;
    end else if (!rstSync) begin
      state <= IOD_Q1;
    end else begin
      state <= next_state; // see [RL5]
    end
  end

  assign phase      = state;
  assign cycleStart = rstSync && (state == IOD_Q1);

  ////////////////////////////////////////////////////////////////////////////
  // Latched instruction for the cycle; a flushed cycle runs as no-op
  logic [13:0] curWord;
  logic        flushNext;

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      curWord    <= IOD_NOP_WORD;
      inNopCycle <= 1'b0;
      flushNext  <= 1'b0;
    end else if (cycleStart) begin
      inNopCycle <= flushNext || !instrValid;
      curWord    <= (flushNext || !instrValid) ? IOD_NOP_WORD : word; // see [RL6]
      flushNext  <= 1'b0;
    end else if (state == IOD_Q4 && !inNopCycle && branchTaken) begin
      flushNext <= 1'b1; // see [RL6]
    end
  end

  logic [1:0] curCls;
  logic [6:0] curAddr;
  logic [2:0] curBit;
  logic       curDest;
  logic       curFile;

  assign curCls  = word_class(curWord);
  assign curAddr = curWord[IOD_F_LSB +: IOD_ADDR_W]; // see [RL2] see [RL9]
  assign curBit  = curWord[IOD_B_LSB +: 3]; // see [RL3]
  // Bit ops always write back to the file register
  assign curDest = (curCls == IOD_CLS_BIT) ? 1'b1 : curWord[IOD_D_POS]; // see [RL1]
  assign curFile = !inNopCycle
                   && ((curCls == IOD_CLS_BYTE) || (curCls == IOD_CLS_BIT)); // see [RL7]

  ////////////////////////////////////////////////////////////////////////////
  // Register file: read in Q2, data back in Q3, write in Q4
  logic [7:0] rfData;
  logic [7:0] result;
  logic       rfWr;

  iod_regfile #(
    .ADDR_W (IOD_ADDR_W),
    .DATA_W (IOD_DATA_W)
  ) uRegfile (
    .clk    (ref_clk),
    .rdAddr (curAddr),
    .rdData (rfData),
    .wrEn   (rfWr),
    .wrAddr (curAddr),
    .wrData (result)
  );

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      fileOperand <= 8'h00;
    end else if (state == IOD_Q3 && curFile) begin
      fileOperand <= rfData; // see [RL7]
    end
  end

  // Read is performed even for write-only ops, so port reads fire here
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      portReadStrobe <= 1'b0;
    end else begin
      portReadStrobe <= (state == IOD_Q2) && curFile && (curAddr == IOD_PORT2_ADDR); // see [RL8]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Operation; aluOp stands in for the external opcode table
  always_comb begin
    case (curCls)
      IOD_CLS_BIT: begin
        result = aluOp[0] ? (fileOperand | (8'h01 << curBit))
                          : (fileOperand & ~(8'h01 << curBit)); // see [RL3]
      end
      IOD_CLS_BYTE: begin
        case (aluOp)
          4'h0:    result = 8'h00;
          4'h1:    result = fileOperand + accum;
          4'h2:    result = fileOperand & accum;
          4'h3:    result = fileOperand | accum;
          4'h4:    result = fileOperand ^ accum;
          4'h5:    result = ~fileOperand;
          4'h6:    result = fileOperand + 8'h01;
          4'h7:    result = fileOperand - 8'h01;
          4'h8:    result = accum;
          default: result = fileOperand;
        endcase
      end
      default: result = curWord[IOD_K8_LSB +: 8]; // see [RL4]
    endcase
  end

  assign rfWr = (state == IOD_Q4) && curFile && curDest; // see [RL1]

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      accum <= IOD_W_RESET;
    end else if (state == IOD_Q4 && !inNopCycle) begin
      if (curFile && !curDest) begin
        accum <= result; // see [RL1]
      end else if (curCls == IOD_CLS_LIT) begin
        accum <= result;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      literal8  <= 8'h00;
      literal11 <= 11'h000;
    end else if (state == IOD_Q2 && !inNopCycle) begin
      literal8  <= curWord[IOD_K8_LSB +: 8]; // see [RL4]
      literal11 <= curWord[IOD_K11_LSB +: 11]; // see [RL4]
    end
  end
endmodule
`default_nettype wire

// ==== pkg/iod_pkg.sv ====
// Constants for the instruction operand decoder.
// Assumes a 14-bit instruction word and a 128-entry operand register file.
`default_nettype none
package iod_pkg;
  localparam int IOD_WORD_W = 14;
  localparam int IOD_ADDR_W = 7;
  localparam int IOD_DATA_W = 8;
  // Field positions within the instruction word
  localparam int IOD_F_LSB  = 0;
  localparam int IOD_D_POS  = 7;
  localparam int IOD_B_LSB  = 7;
  localparam int IOD_K8_LSB = 0;
  localparam int IOD_K11_LSB = 0;
  localparam logic [1:0] IOD_CLS_BYTE = 2'h0;
  localparam logic [1:0] IOD_CLS_BIT  = 2'h1;
  localparam logic [1:0] IOD_CLS_CALL = 2'h2;
  localparam logic [1:0] IOD_CLS_LIT  = 2'h3;
  // Oscillator periods per instruction cycle
  localparam int IOD_PHASES = 4;
  // Address of the second port register
  localparam logic [6:0] IOD_PORT2_ADDR = 7'h06;
  localparam logic [7:0] IOD_W_RESET = 8'h00;
  localparam logic [13:0] IOD_NOP_WORD = 14'h0000;

  typedef enum logic [3:0] {
    IOD_Q1 = 4'b0001,
    IOD_Q2 = 4'b0010,
    IOD_Q3 = 4'b0100,
    IOD_Q4 = 4'b1000
  } iod_phase_t;
endpackage
`default_nettype wire

// ==== design/iod_regfile.sv ====
// Operand register file, 8-bit words, registered read data.
// Assumes one read and one write per instruction cycle from the decoder.
`default_nettype none
module iod_regfile
  import iod_pkg::*;
#(
  parameter int ADDR_W = 7,
  parameter int DATA_W = 8
) (
  input  wire logic              clk,
  input  wire logic [ADDR_W-1:0] rdAddr,
  output logic      [DATA_W-1:0] rdData,
  input  wire logic              wrEn,
  input  wire logic [ADDR_W-1:0] wrAddr,
  input  wire logic [DATA_W-1:0] wrData
);
  logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];

  always_ff @(posedge clk) begin
    if (wrEn) begin
      mem[wrAddr] <= wrData;
    end
    rdData <= mem[rdAddr];
  end
endmodule
`default_nettype wire

// ==== tb/iod_core_props.sv ====
// Checker for the decoder's cycle timing and operand outputs.
// Sees only iod_core ports; bound below.
`default_nettype none
module iod_core_chk
  import iod_pkg::*;
#(
  parameter int WORD_W = IOD_WORD_W
) (
  input wire logic              ref_clk,
  input wire logic              arst_n,
  input wire logic [WORD_W-1:0] instrWord,
  input wire logic              branchTaken,
  input wire logic              cycleStart,
  input wire logic [3:0]        phase,
  input wire logic [7:0]        accum,
  input wire logic [10:0]       literal11,
  input wire logic [7:0]        literal8,
  input wire logic              inNopCycle,
  input wire logic              portReadStrobe
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  wire logic live = !inNopCycle;
  wire logic onPort = !instrWord[13] && instrWord[6:0] == IOD_PORT2_ADDR;
  // Starts at Q2 because Q1 is held while reset leaves the synchroniser
  sequence phase_tail;
    phase == IOD_Q3 ##1 phase == IOD_Q4 ##1 phase == IOD_Q1;
  endsequence
  ////////////////////////////////////////////////////////////////////////////
  phase_walk_a: assert property (phase == IOD_Q2 |=> phase_tail)
    else $error("phase order broken");
  start_period_a: assert property (cycleStart |-> phase == IOD_Q1 ##4 cycleStart)
    else $error("cycle start not every four clocks");
  acc_edge_a: assert property (phase != IOD_Q4 |=> $stable(accum))
    else $error("accumulator changed mid cycle");
  dest_file_a: assert property (phase == IOD_Q4 && live
    && instrWord[13:12] == IOD_CLS_BYTE && instrWord[IOD_D_POS] |=> $stable(accum))
    else $error("file result hit accumulator");
  nop_keep_a: assert property (phase == IOD_Q4 && inNopCycle |=> $stable(accum))
    else $error("no-op cycle wrote accumulator");
  flush_next_a: assert property (phase == IOD_Q4 && branchTaken && live
    |=> ##[0:3] inNopCycle) else $error("taken branch not followed by no-op");
  lit_load_a: assert property (phase == IOD_Q3 && live
    |-> literal8 == instrWord[7:0] && literal11 == instrWord[10:0])
    else $error("literal fields wrong");
  port_only_a: assert property (portReadStrobe |-> phase == IOD_Q3 && onPort)
    else $error("port strobe without port access");
  port_read_a: assert property (phase == IOD_Q3 && live && onPort |-> portReadStrobe)
    else $error("port access gave no strobe");
endmodule
bind iod_core iod_core_chk #(.WORD_W(WORD_W)) chk (.ref_clk(ref_clk), .arst_n(arst_n),
  .instrWord(instrWord), .branchTaken(branchTaken), .cycleStart(cycleStart), .phase(phase),
  .accum(accum), .literal11(literal11), .literal8(literal8), .inNopCycle(inNopCycle),
  .portReadStrobe(portReadStrobe));
`default_nettype wire

// ==== tb/iod_pmem.sv ====
// Program memory model: one word per request, swapped only at a cycle edge.
// Assumes wordReq is raised before Q4 and dropped on the following edge.
`default_nettype none
module iod_pmem
  import iod_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic [3:0]  phase,
  input  wire logic        wordReq,
  input  wire logic [13:0] nextWord,
  output logic      [13:0] instrWord,
  output logic             instrValid
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    instrWord = IOD_NOP_WORD;
    instrValid = 1'b0;
  end
  // Idle cycles show the previous word inverted; a second idle cycle in a row shows the last word again
  always @(posedge ref_clk) begin
    if (phase == IOD_Q4) begin
      instrValid <= wordReq;
      instrWord  <= wordReq ? nextWord : ~instrWord;
    end
  end
endmodule
`default_nettype wire

// ==== tb/test_iod_core.sv ====
// Self-checking bench for iod_core with a program memory model.
// Assumes the design notes' class, field and operation coding.
`default_nettype none
module test_iod_core
  import iod_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        ref_clk, arst_n, wordReq, branchTaken, instrValid, cycleStart, inNopCycle;
  logic        portReadStrobe;
  logic [13:0] nextWord, instrWord;
  logic [3:0]  aluOp, phase;
  logic [7:0]  accum, literal8, fileOperand, acc, rf [128];
  logic [10:0] literal11;
  logic [10:0] nStrobe = 11'h000;
  logic [6:0]  adr [4] = '{7'h00, 7'h06, 7'h7f, 7'h2a};
  int          nMismatch, nChecks;
  iod_core dut (.ref_clk(ref_clk), .arst_n(arst_n), .instrWord(instrWord),
    .instrValid(instrValid), .branchTaken(branchTaken), .aluOp(aluOp), .cycleStart(cycleStart),
    .phase(phase), .accum(accum), .literal11(literal11), .literal8(literal8),
    .inNopCycle(inNopCycle), .portReadStrobe(portReadStrobe), .fileOperand(fileOperand));
  iod_pmem mem (.ref_clk(ref_clk), .phase(phase), .wordReq(wordReq), .nextWord(nextWord),
    .instrWord(instrWord), .instrValid(instrValid));
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  always @(negedge ref_clk) if (portReadStrobe === 1'b1) nStrobe++;
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] alu(logic [3:0] op, logic [7:0] w, logic [7:0] f);
    case (op)
      4'h0: return 8'h00;
      4'h1: return w + f;
      4'h2: return w & f;
      4'h3: return w | f;
      4'h4: return w ^ f;
      4'h5: return ~f;
      4'h6: return f + 8'h01;
      4'h7: return f - 8'h01;
      4'h8: return w;
      default: return f;
    endcase
  endfunction
  task automatic check(string name, logic [10:0] exp, logic [10:0] got);
    nChecks++;
    if (got !== exp) begin
      nMismatch++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", nChecks, nMismatch);
    if (nMismatch == 0 && nChecks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Bounded wait; a stuck sequencer ends the run
  task automatic to_phase(logic [3:0] p);
    int i;
    i = 0;
    do begin
      @(negedge ref_clk);
      i++;
    end while (phase !== p && i < 9);
    if (i == 9) begin
      nMismatch++;
      close_out();
    end
  endtask
  // Word goes to memory in Q3; it runs in the following cycle
  task automatic exec(logic [13:0] w, logic [3:0] op, logic br);
    logic [7:0]  r;
    logic [6:0]  f;
    logic [10:0] s0;
    f = w[6:0];
    to_phase(IOD_Q2);
    check("inNopCycle", 11'h001, inNopCycle);
    @(posedge ref_clk);
    nextWord <= w;
    wordReq  <= 1'b1;
    to_phase(IOD_Q4);
    @(posedge ref_clk);
    // After a taken branch a live word follows at once; it must be dropped
    wordReq     <= br;
    nextWord    <= {IOD_CLS_LIT, ~w[11:0]};
    aluOp       <= op;
    branchTaken <= br;
    s0 = nStrobe;
    to_phase(IOD_Q4);
    check("inNopCycle", 11'h000, inNopCycle);
    check("literal8", w[7:0], literal8);
    check("literal11", w[10:0], literal11);
    r = rf[f];
    if (!w[13] && !$isunknown(r)) check("fileOperand", r, fileOperand);
    if (w[13:12] == IOD_CLS_BYTE) begin
      r = alu(op, acc, r);
      if (w[IOD_D_POS]) rf[f] = r;
      else acc = r;
    end else if (w[13:12] == IOD_CLS_BIT) rf[f][w[9:7]] = op[0];
    else if (w[13:12] == IOD_CLS_LIT) acc = w[7:0];
    @(posedge ref_clk);
    wordReq <= 1'b0;
    to_phase(IOD_Q1);
    check("portReadStrobe", !w[13] && f == IOD_PORT2_ADDR, nStrobe - s0);
    if (!$isunknown(acc)) check("accum", acc, accum);
  endtask
  initial begin
    arst_n = 1'b0;
    wordReq = 1'b0;
    nextWord = IOD_NOP_WORD;
    aluOp = 4'h0;
    branchTaken = 1'b0;
    acc = IOD_W_RESET;
    void'($urandom(20));
    repeat (2) @(posedge ref_clk);
    arst_n <= 1'b1;
    @(negedge ref_clk);
    check("accum", IOD_W_RESET, accum);
    exec({IOD_CLS_LIT, 12'($urandom)}, 4'h0, 1'b0);
    exec({IOD_CLS_CALL, 12'($urandom)}, 4'h0, 1'b1);
    exec({IOD_CLS_BYTE, 5'h00, IOD_PORT2_ADDR}, 4'h0, 1'b0);
    for (int j = 0; j < 4; j++) exec({IOD_CLS_BYTE, 5'h01, adr[j]}, 4'h0, 1'b0);
    for (int i = 0; i < 60; i++) begin
      exec({1'b0, 1'($urandom), 5'($urandom), adr[$urandom % 4]}, 4'($urandom % 10),
        $urandom % 4 == 0);
    end
    close_out();
  end
endmodule
`default_nettype wire
